// ==== gpio_pkg.sv ====
// Constants, field layouts and carrier types for the programmable pin routing port.
// Assumes one 25 MHz clock, an active-low asynchronous reset and a plain register port.
// ****************************************************************************
// ****************************************************************************
package gpio_pkg;

	// ************************************************************************
	// Sizes
	// ************************************************************************
	localparam int NPINS  = 25;
	localparam int NPORTS = 4;
	localparam int NPID   = 32;
	localparam int NADC   = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int NQUAD  = 3;
	localparam int QSEL_W = 4;
	localparam int NPAIRS = 12;
	localparam int PORT_BASE  [NPORTS] = '{0, 8, 14, 24};
	localparam int PORT_WIDTH [NPORTS] = '{8, 6, 10, 1};

	// Debug pins, port 1 pins 4 and 5.
	localparam int SWCLK_PIN = 12;
	localparam int SWDIO_PIN = 13;

	// ************************************************************************
	// Register map, byte addresses
	// ************************************************************************
	localparam logic [ADDR_W-1:0] CFG_BASE   = 8'h00;
	localparam logic [ADDR_W-1:0] CFG_END    = 8'h64;
	localparam logic [1:0]        PORT_SPACE = 2'h2;
	localparam logic [1:0]        PREG_DATA  = 2'h0;
	localparam logic [1:0]        PREG_SET   = 2'h1;
	localparam logic [1:0]        PREG_CLEAR = 2'h2;
	localparam logic [ADDR_W-1:0] SYSCTL_ADDR = 8'hC0;
	localparam logic [ADDR_W-1:0] QUAD_ADDR   = 8'hC4;

	// ************************************************************************
	// Field positions and codes
	// ************************************************************************
	localparam int PID_LSB = 0;
	localparam int DIR_LSB = 8;
	localparam int SYS_DEBUG_BIT  = 0;
	localparam int SYS_RETAIN_BIT = 1;
	localparam logic [1:0] DIR_IN      = 2'h0;
	localparam logic [1:0] DIR_IN_PU   = 2'h1;
	localparam logic [1:0] DIR_IN_PD   = 2'h2;
	localparam logic [1:0] DIR_OUT     = 2'h3;
	localparam logic [4:0] PID_GPIO    = 5'h00;
	localparam logic [4:0] PID_ADC     = 5'h0F;

	// ************************************************************************
	// Reset values
	// ************************************************************************
	localparam logic [4:0] RST_PID        = 5'h00;
	localparam logic [1:0] RST_DIR        = 2'h0;
	localparam logic       RST_DEBUG_EN   = 1'b1;
	localparam logic       RST_RETAIN_EN  = 1'b0;
	localparam logic [QSEL_W-1:0] RST_QSEL [NQUAD] = '{4'h0, 4'h1, 4'h2};

	// ************************************************************************
	// Carrier types
	// ************************************************************************
	typedef struct packed {
		logic [1:0] dir;
		logic [4:0] peripheral_select_id;
	} pin_cfg_t;

	typedef struct packed {
		logic out;
		logic oe;
		logic pull_up;
		logic pull_down;
		logic analog;
	} pad_ctrl_t;

	typedef struct packed {
		logic quad_x_phase_a;
		logic quad_x_phase_b;
		logic quad_y_phase_a;
		logic quad_y_phase_b;
		logic quad_z_phase_a;
		logic quad_z_phase_b;
	} quad_in_t;

endpackage : gpio_pkg

// ==== input_router.sv ====
// Combinational selection of each peripheral input from the routed pins.
// Assumes synchronised pin levels and the identifier field of every pin.
`timescale 1ns/1ps

module input_router import gpio_pkg::*; (
	// Pin side
	input  wire logic [NPINS-1:0]      pin_level,
	input  wire logic [NPINS-1:0][4:0] pin_pid,
	// Peripheral side
	output logic      [NPID-1:0]       periph_level
);

	// Walk pins from the highest down so the lowest numbered match is the last one kept.
	always_comb begin
		periph_level = '0;
		for (int p = 1; p < NPID; p++) begin
			for (int i = NPINS - 1; i >= 0; i--) begin
				if (pin_pid[i] == 5'(p)) begin
					periph_level[p] = pin_level[i];
				end
			end
		end
	end

endmodule : input_router

// ==== gpio_port.sv ====
// Programmable pin routing port: pin configuration, port data, set and clear registers.
// Assumes pads outside the clock domain, peripherals and debug core on the same clock.
`timescale 1ns/1ps

module gpio_port import gpio_pkg::*; (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// Register port
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_write,
	input  wire logic              reg_read,
	output logic      [DATA_W-1:0] reg_rdata,
	// Pads
	input  wire logic [NPINS-1:0]  pad_in,
	output pad_ctrl_t              pad_ctrl [NPINS],
	// Peripherals
	input  wire logic [NPID-1:0]   periph_out,
	output logic      [NPID-1:0]   periph_in,
	output quad_in_t               quad_in,
	// Debug core
	input  wire logic              swdio_out,
	input  wire logic              swdio_oe,
	output logic                   swclk_in,
	output logic                   swdio_in,
	// Power state
	input  wire logic              sleep_mode
);

	// ************************************************************************
	// Functions
	// ************************************************************************

	// Mask of the pins that belong to a port.
	function automatic logic [NPINS-1:0] port_mask(input logic [1:0] port);
		logic [NPINS-1:0] m;
		m = '0;
		for (int i = 0; i < NPINS; i++) begin
			if (i >= PORT_BASE[port] && i < PORT_BASE[port] + PORT_WIDTH[port]) begin
				m[i] = 1'b1;
			end
		end
		return m;
	endfunction : port_mask

	// Places port-relative data bits on their global pin positions.
	function automatic logic [NPINS-1:0] port_spread(input logic [1:0] port, input logic [DATA_W-1:0] val);
		logic [NPINS-1:0] v;
		v = '0;
		for (int i = 0; i < NPINS; i++) begin
			if (i >= PORT_BASE[port] && i < PORT_BASE[port] + PORT_WIDTH[port]) begin
				v[i] = val[i - PORT_BASE[port]];
			end
		end
		return v;
	endfunction : port_spread

	// ************************************************************************
	// State and decode
	// ************************************************************************
	logic [NPINS-1:0]  pad_meta;
	logic [NPINS-1:0]  pad_sync;
	pin_cfg_t          cfg_reg [NPINS];
	logic [NPINS-1:0]  out_data_reg;
	logic              debug_en_reg;
	logic              retain_en_reg;
	logic [QSEL_W-1:0] qsel_reg [NQUAD];
	logic [NPINS-1:0]  analog_sel;
	logic [NPINS-1:0]  level_rd;
	logic [NPINS-1:0][4:0] pid_vec;
	logic [NPID-1:0]   routed_in;
	pad_ctrl_t         pad_next [NPINS];
	logic              cfg_hit;
	logic [4:0]        cfg_idx;
	logic              port_hit;
	logic [1:0]        port_sel;
	logic [1:0]        preg_sel;
	logic [NPINS-1:0]  wr_mask;
	logic [NPINS-1:0]  wr_spread;
	logic              hold_pads;

	// Address decode of the register port.
	assign cfg_hit   = (reg_addr >= CFG_BASE) && (reg_addr < CFG_END) && (reg_addr[1:0] == 2'h0);
	assign cfg_idx   = reg_addr[6:2];
	assign port_hit  = (reg_addr[7:6] == PORT_SPACE) && (reg_addr[1:0] == 2'h0);
	assign port_sel  = reg_addr[5:4];
	assign preg_sel  = reg_addr[3:2];
	assign wr_mask   = port_mask(port_sel);
	assign wr_spread = port_spread(port_sel, reg_wdata);
	assign hold_pads = sleep_mode && retain_en_reg;

	// ************************************************************************
	// Pad input synchronisers
	// ************************************************************************

	// Two flops before any logic sees a pad level.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_meta <= '0;
			pad_sync <= '0;
		end else begin
			pad_meta <= pad_in;
			pad_sync <= pad_meta;
		end
	end

	// ************************************************************************
	// Configuration registers
	// ************************************************************************

	// Pin configuration, one register per pin across all four ports.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NPINS; i++) begin
				cfg_reg[i] <= '{dir: RST_DIR, peripheral_select_id: RST_PID};
			end
		end else if (reg_write && cfg_hit) begin
			cfg_reg[cfg_idx] <= '{dir: reg_wdata[DIR_LSB +: 2], peripheral_select_id: reg_wdata[PID_LSB +: 5]};
		end
	end

	// System control and quadrature pair selection.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			debug_en_reg  <= RST_DEBUG_EN;
			retain_en_reg <= RST_RETAIN_EN;
			for (int c = 0; c < NQUAD; c++) begin
				qsel_reg[c] <= RST_QSEL[c];
			end
		end else if (reg_write && reg_addr == SYSCTL_ADDR) begin
			debug_en_reg  <= reg_wdata[SYS_DEBUG_BIT];
			retain_en_reg <= reg_wdata[SYS_RETAIN_BIT];
		end else if (reg_write && reg_addr == QUAD_ADDR) begin
			for (int c = 0; c < NQUAD; c++) begin
				qsel_reg[c] <= reg_wdata[c*QSEL_W +: QSEL_W];
			end
		end
	end

	// ************************************************************************
	// Port output data
	// ************************************************************************

	// Data, set and clear writes each touch only the addressed port.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_data_reg <= '0;
		end else if (reg_write && port_hit) begin
			unique case (preg_sel)
				PREG_DATA:  out_data_reg <= (out_data_reg & ~wr_mask) | (wr_spread & wr_mask);
				PREG_SET:   out_data_reg <= out_data_reg | (wr_spread & wr_mask);
				PREG_CLEAR: out_data_reg <= out_data_reg & ~(wr_spread & wr_mask);
				default:    out_data_reg <= out_data_reg;
			endcase
		end
	end

	// ************************************************************************
	// Read path
	// ************************************************************************

	// Analog selection exists only on the converter pins; such pins read as zero.
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			analog_sel[i] = (i < NADC) && (cfg_reg[i].peripheral_select_id == PID_ADC);
			level_rd[i]   = pad_sync[i] & ~analog_sel[i];
			pid_vec[i]    = cfg_reg[i].peripheral_select_id;
		end
	end

	// Read data stands for one cycle after the strobe, zero otherwise or when unmapped.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= '0;
		end else if (!reg_read) begin
			reg_rdata <= '0;
		end else if (cfg_hit) begin
			reg_rdata <= DATA_W'({cfg_reg[cfg_idx].dir, 3'h0, cfg_reg[cfg_idx].peripheral_select_id});
		end else if (port_hit && preg_sel == PREG_DATA) begin
			reg_rdata <= DATA_W'((level_rd & port_mask(port_sel)) >> PORT_BASE[port_sel]);
		end else if (reg_addr == SYSCTL_ADDR) begin
			reg_rdata <= DATA_W'({retain_en_reg, debug_en_reg});
		end else if (reg_addr == QUAD_ADDR) begin
			reg_rdata <= DATA_W'({qsel_reg[2], qsel_reg[1], qsel_reg[0]});
		end else begin
			reg_rdata <= '0;
		end
	end

	// ************************************************************************
	// Pad drive
	// ************************************************************************

	// Next pad controls from direction, routing and the debug override.
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			pad_next[i].analog    = analog_sel[i];
			pad_next[i].oe        = (cfg_reg[i].dir == DIR_OUT) && !analog_sel[i];
			pad_next[i].out       = (cfg_reg[i].peripheral_select_id == PID_GPIO) ? out_data_reg[i] : periph_out[cfg_reg[i].peripheral_select_id];
			pad_next[i].pull_up   = (cfg_reg[i].dir == DIR_IN_PU) && !analog_sel[i];
			pad_next[i].pull_down = (cfg_reg[i].dir == DIR_IN_PD) && !analog_sel[i];
		end
		if (debug_en_reg) begin
			pad_next[SWCLK_PIN] = '{out: 1'b0, oe: 1'b0, pull_up: 1'b0, pull_down: 1'b0, analog: 1'b0};
			pad_next[SWDIO_PIN] = '{out: swdio_out, oe: swdio_oe, pull_up: 1'b0, pull_down: 1'b0, analog: 1'b0};
		end
	end

	// Pads freeze on their last state while retention is enabled and sleep_mode is high.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NPINS; i++) begin
				pad_ctrl[i] <= '0;
			end
		end else if (!hold_pads) begin
			for (int i = 0; i < NPINS; i++) begin
				pad_ctrl[i] <= pad_next[i];
			end
		end
	end

	// ************************************************************************
	// Peripheral inputs
	// ************************************************************************
	input_router u_input_router (
		.pin_level    (pad_sync),
		.pin_pid      (pid_vec),
		.periph_level (routed_in)
	);

	// Registered peripheral, quadrature and debug inputs.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_in <= '0;
			quad_in   <= '0;
			swclk_in  <= 1'b0;
			swdio_in  <= 1'b0;
		end else begin
			periph_in <= routed_in;
			quad_in.quad_x_phase_a <= (qsel_reg[0] < NPAIRS) ? pad_sync[{qsel_reg[0], 1'b0}] : 1'b0;
			quad_in.quad_x_phase_b <= (qsel_reg[0] < NPAIRS) ? pad_sync[{qsel_reg[0], 1'b1}] : 1'b0;
			quad_in.quad_y_phase_a <= (qsel_reg[1] < NPAIRS) ? pad_sync[{qsel_reg[1], 1'b0}] : 1'b0;
			quad_in.quad_y_phase_b <= (qsel_reg[1] < NPAIRS) ? pad_sync[{qsel_reg[1], 1'b1}] : 1'b0;
			quad_in.quad_z_phase_a <= (qsel_reg[2] < NPAIRS) ? pad_sync[{qsel_reg[2], 1'b0}] : 1'b0;
			quad_in.quad_z_phase_b <= (qsel_reg[2] < NPAIRS) ? pad_sync[{qsel_reg[2], 1'b1}] : 1'b0;
			swclk_in  <= debug_en_reg & pad_sync[SWCLK_PIN];
			swdio_in  <= debug_en_reg & pad_sync[SWDIO_PIN];
		end
	end

	// ************************************************************************
	// Assertions
	// ************************************************************************
	logic [NPINS-1:0] pull_bad;

	// Any pin pulling while driving or analog.
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			pull_bad[i] = (pad_ctrl[i].oe || pad_ctrl[i].analog) && (pad_ctrl[i].pull_up || pad_ctrl[i].pull_down);
		end
	end

	property p_cfg_write;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && cfg_hit) |=> (cfg_reg[$past(cfg_idx)] == pin_cfg_t'({$past(reg_wdata[9:8]), $past(reg_wdata[4:0])}));
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("pin configuration write not stored");

	property p_data_write;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && port_hit && preg_sel == PREG_DATA) |=> ((out_data_reg & $past(wr_mask)) == ($past(wr_spread) & $past(wr_mask)));
	endproperty
	a_data_write: assert property (p_data_write) else $error("port data write not stored");

	property p_set;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && port_hit && preg_sel == PREG_SET) |=>
			(((out_data_reg ^ $past(out_data_reg)) & ~($past(wr_spread) & $past(wr_mask))) == '0) &&
			((out_data_reg & $past(wr_spread) & $past(wr_mask)) == ($past(wr_spread) & $past(wr_mask)));
	endproperty
	a_set: assert property (p_set) else $error("output set wrong");

	property p_clear;
		@(posedge clk) disable iff (!rst_n)
		(reg_write && port_hit && preg_sel == PREG_CLEAR) |=>
			(((out_data_reg ^ $past(out_data_reg)) & ~($past(wr_spread) & $past(wr_mask))) == '0) &&
			((out_data_reg & $past(wr_spread) & $past(wr_mask)) == '0);
	endproperty
	a_clear: assert property (p_clear) else $error("output clear wrong");

	property p_analog_read;
		@(posedge clk) disable iff (!rst_n)
		(reg_read && reg_addr == 8'h80 && analog_sel[0]) |=> (reg_rdata[0] == 1'b0);
	endproperty
	a_analog_read: assert property (p_analog_read) else $error("analog pin did not read zero");

	property p_no_pull;
		@(posedge clk) disable iff (!rst_n)
		1'b1 |-> (pull_bad == '0);
	endproperty
	a_no_pull: assert property (p_no_pull) else $error("pull enabled on output or analog pin");

	property p_gpio_drive;
		@(posedge clk) disable iff (!rst_n)
		(!hold_pads && cfg_reg[8].peripheral_select_id == PID_GPIO && cfg_reg[8].dir == DIR_OUT) |=>
			(pad_ctrl[8].oe && pad_ctrl[8].out == $past(out_data_reg[8]));
	endproperty
	a_gpio_drive: assert property (p_gpio_drive) else $error("stored output not driven on pin");

	property p_retain;
		@(posedge clk) disable iff (!rst_n)
		hold_pads |=> ($stable(pad_ctrl[8]) && $stable(pad_ctrl[SWDIO_PIN]));
	endproperty
	a_retain: assert property (p_retain) else $error("pad changed while retained");

	property p_priority;
		@(posedge clk) disable iff (!rst_n)
		(cfg_reg[0].peripheral_select_id != PID_GPIO) |=> (periph_in[$past(cfg_reg[0].peripheral_select_id)] == $past(pad_sync[0]));
	endproperty
	a_priority: assert property (p_priority) else $error("lowest pin lost input priority");

endmodule : gpio_port

// ==== pad_model.sv ====
// Behavioural model of the package pads as seen from outside the port.
// Assumes the port's clock; a pin that nobody drives floats.
`timescale 1ns/1ps

module pad_model import gpio_pkg::*; (
	// Clock
	input  wire logic             clk,
	// Port side
	input  wire pad_ctrl_t        pad_ctrl [NPINS],
	output logic      [NPINS-1:0] pad_in,
	// Board side
	input  wire logic [NPINS-1:0] ext_en,
	input  wire logic [NPINS-1:0] ext_val
);
	logic flt_reg = 1'b0;

	// A floating pin shows a level that changes every cycle, so nothing passes by luck.
	always @(posedge clk) begin
		flt_reg <= ~flt_reg;
	end

	// The pad driver wins, then the board, then the pull resistors.
	always_comb begin
		for (int i = 0; i < NPINS; i++) begin
			pad_in[i] = pad_ctrl[i].oe ? pad_ctrl[i].out :
				ext_en[i] ? ext_val[i] :
				pad_ctrl[i].pull_up ? 1'b1 :
				pad_ctrl[i].pull_down ? 1'b0 : flt_reg;
		end
	end

endmodule : pad_model

// ==== gpio_port_tb.sv ====
// Self-checking bench for the programmable pin routing port.
// Assumes the pad model beside it and the register map of the package.
`timescale 1ns/1ps

module gpio_port_tb import gpio_pkg::*;;
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp;
	} row_t;

	logic              clk;
	logic              rst_n;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata;
	logic              reg_write;
	logic              reg_read;
	logic [DATA_W-1:0] reg_rdata;
	logic [NPINS-1:0]  pad_in;
	pad_ctrl_t         pad_ctrl [NPINS];
	logic [NPID-1:0]   periph_out;
	logic [NPID-1:0]   periph_in;
	quad_in_t          quad_in;
	logic              swdio_out;
	logic              swdio_oe;
	logic              swclk_in;
	logic              swdio_in;
	logic              sleep_mode;
	logic [NPINS-1:0]  ext_en;
	logic [NPINS-1:0]  ext_val;
	logic [DATA_W-1:0] got;
	int                fails;
	int                total_checks;
	int                cycles;

	// Write, read back, expected value.
	row_t rows [6] = '{
		'{8'h28, 16'h0305, 16'h0305},
		'{8'h2C, 16'hFFFF, 16'h031F},
		'{8'h60, 16'h021F, 16'h021F},
		'{8'h70, 16'h1234, 16'h0000},
		'{8'h84, 16'h0000, 16'h0000},
		'{8'hC4, 16'h0543, 16'h0543}
	};

	gpio_port u_gpio_port (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .pad_in(pad_in),
		.pad_ctrl(pad_ctrl), .periph_out(periph_out), .periph_in(periph_in), .quad_in(quad_in),
		.swdio_out(swdio_out), .swdio_oe(swdio_oe), .swclk_in(swclk_in), .swdio_in(swdio_in),
		.sleep_mode(sleep_mode));

	pad_model u_pad_model (.clk(clk), .pad_ctrl(pad_ctrl), .pad_in(pad_in), .ext_en(ext_en),
		.ext_val(ext_val));

	// ************************************************************************
	// Tasks
	// ************************************************************************
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe.
	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		got = reg_rdata;
	endtask : rd

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic chk16(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t: word %h, expected %h", $time, g, e);
		end
	endtask : chk16

	task automatic chk1(input logic g, input logic e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t: bit %b, expected %b", $time, g, e);
		end
	endtask : chk1

	task automatic print_verdict;
		$display("checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	// ************************************************************************
	// Clock, timeout and stimulus
	// ************************************************************************
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Cuts a hang short well beyond the roughly 120 cycles the tests need.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			print_verdict();
		end
	end

	initial begin
		rst_n      = 1'b0;
		reg_addr   = '0;
		reg_wdata  = '0;
		reg_write  = 1'b0;
		reg_read   = 1'b0;
		periph_out = '0;
		swdio_out  = 1'b0;
		swdio_oe   = 1'b1;
		sleep_mode = 1'b0;
		ext_val    = '0;
		ext_en     = 25'h1EFD4FF;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr);
			chk16(got, rows[i].exp);
		end
		// General-purpose outputs through data, set and clear.
		wr(8'h20, 16'h0300);
		wr(8'h24, 16'h0300);
		wr(8'h90, 16'h0001);
		cyc(3);
		chk1(pad_ctrl[8].oe, 1'b1);
		chk1(pad_ctrl[8].out, 1'b1);
		chk1(pad_ctrl[8].pull_up | pad_ctrl[8].pull_down, 1'b0);
		wr(8'h94, 16'h0002);
		cyc(3);
		rd(8'h90);
		chk16(got, 16'h0003);
		wr(8'h98, 16'h0001);
		cyc(3);
		chk1(pad_ctrl[8].out, 1'b0);
		chk1(pad_ctrl[9].out, 1'b1);
		rd(8'h90);
		chk16(got, 16'h0002);
		// Pulls and the analog pin.
		ext_en[1] <= 1'b0;
		wr(8'h04, 16'h0100);
		wr(8'h00, 16'h010F);
		ext_val[0] <= 1'b1;
		cyc(4);
		chk1(pad_ctrl[1].pull_up, 1'b1);
		chk1(pad_ctrl[0].pull_up, 1'b0);
		chk1(pad_ctrl[0].analog, 1'b1);
		chk1(pad_ctrl[24].pull_down, 1'b1);
		rd(8'h80);
		chk16(got, 16'h0002);
		// Two pins on one peripheral input.
		wr(8'h0C, 16'h0005);
		ext_val[3] <= 1'b1;
		cyc(5);
		chk1(periph_in[5], 1'b1);
		ext_val[3] <= 1'b0;
		ext_val[10] <= 1'b1;
		periph_out[5] <= 1'b1;
		cyc(5);
		chk1(periph_in[5], 1'b0);
		// Peripheral output routed to a pin.
		wr(8'h50, 16'h0307);
		periph_out[7] <= 1'b1;
		cyc(4);
		chk1(pad_ctrl[20].out, 1'b1);
		// Quadrature pairs x on pins 6 and 7, y on pins 8 and 9.
		ext_val[6] <= 1'b1;
		cyc(5);
		chk1(quad_in.quad_x_phase_a, 1'b1);
		chk1(quad_in.quad_x_phase_b, 1'b0);
		chk1(quad_in.quad_y_phase_a, 1'b0);
		chk1(quad_in.quad_y_phase_b, 1'b1);
		// Debug pins, then turned off.
		ext_val[12] <= 1'b1;
		swdio_out <= 1'b1;
		cyc(5);
		chk1(swclk_in, 1'b1);
		chk1(pad_ctrl[13].oe, 1'b1);
		chk1(swdio_in, 1'b1);
		wr(8'hC0, 16'h0000);
		cyc(3);
		chk1(swclk_in, 1'b0);
		chk1(swdio_in, 1'b0);
		// Retention in sleep freezes the pads.
		wr(8'hC0, 16'h0002);
		sleep_mode <= 1'b1;
		wr(8'h90, 16'h0001);
		cyc(3);
		chk1(pad_ctrl[8].out, 1'b0);
		sleep_mode <= 1'b0;
		cyc(3);
		chk1(pad_ctrl[8].out, 1'b1);
		// Reset in mid-run restores the defaults.
		rst_n <= 1'b0;
		cyc(2);
		chk1(pad_ctrl[8].oe, 1'b0);
		rst_n <= 1'b1;
		rd(8'hC0);
		chk16(got, 16'h0001);
		rd(8'hC4);
		chk16(got, 16'h0210);
		rd(8'h28);
		chk16(got, 16'h0000);
		print_verdict();
	end

endmodule : gpio_port_tb
